/* File: rtl/spme_engine.v */
// Shunt power measurement engine: conversion sequencing, averaging and scaling
// Function
// - Conversion durations from 140us to 8.244ms
// - Shunt and bus durations programmed separately
// - Durations and averaging are fields of setup
// - Average programmable number of results before reporting
// - Front end sampled at nominal 500kHz
// - Power count worth 25 current counts
// - After calibration, results refresh each measurement
// - Without calibration, current and power stay zero
// - Current is shunt times calibration over 2048
// - Power is current times bus over 20000
// - Bus weight 1.25mV, top bit zero
// - Accumulate all four when shunt is enabled, else bus and power only; load only averages
`timescale 1ns/1ps
`include "spme_regs.vh"

module spme_engine #(
  parameter CLK_MHZ = `SPME_CLK_MHZ
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register write port from the serial interface
  input wire wr_i,
  input wire [7:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  // Front end codes and strobes
  input wire [15:0] shunt_code_i,
  input wire [15:0] bus_code_i,
  output reg fe_sample_o,
  output reg fe_bus_sel_o,
  // Register contents
  output reg [15:0] setup_o,
  output reg [15:0] cal_o,
  output reg [15:0] shunt_o,
  output reg [15:0] bus_o,
  output reg [15:0] current_o,
  output reg [15:0] power_o,
  // Status
  output reg conv_ready_o,
  output reg busy_o
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_SHUNT = 6'h02;
  localparam [5:0] S_CUR = 6'h04;
  localparam [5:0] S_BUS = 6'h08;
  localparam [5:0] S_PWR = 6'h10;
  localparam [5:0] S_LOAD = 6'h20;

  reg [5:0] state_reg;
  reg trig_reg;
  reg cal_set_reg;
  reg tstart_reg;
  reg [10:0] smp_cnt_reg;
  reg signed [15:0] cur_smp_reg;
  reg [15:0] bus_smp_reg;
  reg signed [31:0] acc_sh_reg;
  reg signed [31:0] acc_bus_reg;
  reg signed [31:0] acc_cur_reg;
  reg signed [31:0] acc_pwr_reg;

  wire t_tick;
  wire t_done;
  wire [2:0] mode = setup_o[`SPME_MODE_LSB +: 3];
  wire shunt_en = mode[0];
  wire bus_en = mode[1];
  wire cont_en = mode[2];
  wire [2:0] ct_sh = setup_o[`SPME_CT_SHUNT_LSB +: 3];
  wire [2:0] ct_bus = setup_o[`SPME_CT_BUS_LSB +: 3];
  wire [3:0] avg_sh = avg_shift(setup_o[`SPME_AVG_LSB +: 3]);
  wire setup_wr = wr_i && (wr_addr_i == `SPME_SETUP_ADDR);
  wire cal_wr = wr_i && (wr_addr_i == `SPME_CAL_ADDR);
  wire last_smp = (smp_cnt_reg == ((11'h001 << avg_sh) - 11'h001));
  wire [15:0] pwr_smp = calc_power(cur_smp_reg, bus_smp_reg);

  // Averaging count as a shift for a select code
  function [3:0] avg_shift;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: avg_shift = `SPME_AVG0_SHIFT;
        3'h1: avg_shift = `SPME_AVG1_SHIFT;
        3'h2: avg_shift = `SPME_AVG2_SHIFT;
        3'h3: avg_shift = `SPME_AVG3_SHIFT;
        3'h4: avg_shift = `SPME_AVG4_SHIFT;
        3'h5: avg_shift = `SPME_AVG5_SHIFT;
        3'h6: avg_shift = `SPME_AVG6_SHIFT;
        default: avg_shift = `SPME_AVG7_SHIFT;
      endcase
    end
  endfunction

  // Current from signed shunt code and calibration value
  function [15:0] calc_current;
    input [15:0] sh;
    input [15:0] cal;
    reg signed [32:0] p;
    begin
      p = $signed(sh) * $signed({1'b0, cal});
      calc_current = p[`SPME_CUR_SHIFT +: 16];
    end
  endfunction

  // Power from current and bus code; fixes the 25x power weight
  function [15:0] calc_power;
    input [15:0] cur;
    input [15:0] bus;
    reg signed [32:0] p;
    reg signed [32:0] q;
    begin
      p = $signed(cur) * $signed({1'b0, bus});
      q = p / `SPME_PWR_DIV;
      calc_power = q[15:0];
    end
  endfunction

  // Average of an accumulator, truncated to a register
  function [15:0] avg_of;
    input [31:0] acc;
    input [3:0] sh;
    reg signed [31:0] a;
    begin
      a = $signed(acc) >>> sh;
      avg_of = a[15:0];
    end
  endfunction

  // Duration timer shared by both measurements
  spme_conv_timer #(
    .CLK_MHZ(CLK_MHZ)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(tstart_reg),
    .abort_i(setup_wr),
    .ct_sel_i(fe_bus_sel_o ? ct_bus : ct_sh),
    .sample_tick_o(t_tick),
    .done_o(t_done)
  );

  // Setup and calibration registers
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      setup_o <= `SPME_SETUP_RESET;
      cal_o <= 16'h0000;
      cal_set_reg <= 1'b0;
    end else begin
      if (setup_wr) begin
        setup_o <= wr_data_i;
      end
      if (cal_wr) begin
        cal_o <= wr_data_i;
        cal_set_reg <= 1'b1;
      end
    end
  end

  // Front end strobe register
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fe_sample_o <= 1'b0;
    end else begin
      // A setup write stops the strobe together with the aborted round
      fe_sample_o <= t_tick && !setup_wr;
    end
  end

  // Measurement sequencer, accumulation and result load
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      trig_reg <= 1'b1;
      tstart_reg <= 1'b0;
      fe_bus_sel_o <= 1'b0;
      smp_cnt_reg <= 11'h000;
      cur_smp_reg <= 16'h0000;
      bus_smp_reg <= 16'h0000;
      acc_sh_reg <= 32'h00000000;
      acc_bus_reg <= 32'h00000000;
      acc_cur_reg <= 32'h00000000;
      acc_pwr_reg <= 32'h00000000;
      shunt_o <= 16'h0000;
      bus_o <= 16'h0000;
      current_o <= 16'h0000;
      power_o <= 16'h0000;
      conv_ready_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      tstart_reg <= 1'b0;
      // Ready clears on a setup write that is not power-down; no load happens then
      if (setup_wr && (wr_data_i[`SPME_MODE_LSB +: 2] != 2'h0)) begin
        conv_ready_o <= 1'b0;
      end
      if (setup_wr) begin
        // A setup write restarts the sequence and arms a single shot
        state_reg <= S_IDLE;
        trig_reg <= 1'b1;
        busy_o <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            smp_cnt_reg <= 11'h000;
            acc_sh_reg <= 32'h00000000;
            acc_bus_reg <= 32'h00000000;
            acc_cur_reg <= 32'h00000000;
            acc_pwr_reg <= 32'h00000000;
            if ((shunt_en || bus_en) && (trig_reg || cont_en)) begin
              trig_reg <= 1'b0;
              busy_o <= 1'b1;
              tstart_reg <= 1'b1;
              fe_bus_sel_o <= ~shunt_en;
              state_reg <= shunt_en ? S_SHUNT : S_BUS;
            end
          end
          S_SHUNT: begin
            if (t_done) begin
              acc_sh_reg <= acc_sh_reg + {{16{shunt_code_i[15]}}, shunt_code_i};
              cur_smp_reg <= cal_set_reg ? calc_current(shunt_code_i, cal_o) : 16'h0000;
              state_reg <= S_CUR;
            end
          end
          S_CUR: begin
            acc_cur_reg <= acc_cur_reg + {{16{cur_smp_reg[15]}}, cur_smp_reg};
            if (bus_en) begin
              tstart_reg <= 1'b1;
              fe_bus_sel_o <= 1'b1;
              state_reg <= S_BUS;
            end else begin
              state_reg <= S_PWR;
            end
          end
          S_BUS: begin
            if (t_done) begin
              bus_smp_reg <= {1'b0, bus_code_i[14:0]};
              state_reg <= S_PWR;
            end
          end
          S_PWR: begin
            acc_bus_reg <= acc_bus_reg + {16'h0000, bus_smp_reg};
            // Power is signed, so it is sign extended into the accumulator
            acc_pwr_reg <= acc_pwr_reg + (cal_set_reg ?
              {{16{pwr_smp[15]}}, pwr_smp} : 32'h00000000);
            if (last_smp) begin
              state_reg <= S_LOAD;
            end else begin
              // Next sample: period is the sum of enabled durations
              smp_cnt_reg <= smp_cnt_reg + 11'h001;
              tstart_reg <= 1'b1;
              fe_bus_sel_o <= ~shunt_en;
              state_reg <= shunt_en ? S_SHUNT : S_BUS;
            end
          end
          S_LOAD: begin
            if (shunt_en) begin
              shunt_o <= avg_of(acc_sh_reg, avg_sh);
            end
            if (bus_en) begin
              bus_o <= avg_of(acc_bus_reg, avg_sh);
            end
            current_o <= cal_set_reg ? avg_of(acc_cur_reg, avg_sh) : 16'h0000;
            power_o <= cal_set_reg ? avg_of(acc_pwr_reg, avg_sh) : 16'h0000;
            conv_ready_o <= 1'b1;
            busy_o <= 1'b0;
            state_reg <= S_IDLE;
          end
          default: begin
            state_reg <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

/* File: rtl/spme_regs.vh */
// Register offsets, field positions, reset values and timing figures of the measurement engine
`ifndef SPME_REGS_VH
`define SPME_REGS_VH

// Register offsets
`define SPME_SETUP_ADDR 8'h00
`define SPME_CAL_ADDR 8'h05

// Measurement setup reset value and field positions
`define SPME_SETUP_RESET 16'h4127
`define SPME_MODE_LSB 0
`define SPME_CT_SHUNT_LSB 3
`define SPME_CT_BUS_LSB 6
`define SPME_AVG_LSB 9

// Conversion durations in microseconds, one per select code
`define SPME_CT0_US 140
`define SPME_CT1_US 204
`define SPME_CT2_US 332
`define SPME_CT3_US 588
`define SPME_CT4_US 1100
`define SPME_CT5_US 2116
`define SPME_CT6_US 4156
`define SPME_CT7_US 8244

// Averaging count as a power of two, per select code
`define SPME_AVG0_SHIFT 4'h0
`define SPME_AVG1_SHIFT 4'h2
`define SPME_AVG2_SHIFT 4'h4
`define SPME_AVG3_SHIFT 4'h6
`define SPME_AVG4_SHIFT 4'h7
`define SPME_AVG5_SHIFT 4'h8
`define SPME_AVG6_SHIFT 4'h9
`define SPME_AVG7_SHIFT 4'hA

// Front end sampling rate and clock rate
`define SPME_SAMPLE_KHZ 500
`define SPME_CLK_MHZ 200

// Result scaling: current divides by 2048, power by 20000
`define SPME_CUR_SHIFT 11
`define SPME_PWR_DIV 20000

`endif

/* File: rtl/spme_conv_timer.v */
// Conversion duration timer and front end sample strobe generator
`timescale 1ns/1ps
`include "spme_regs.vh"

module spme_conv_timer #(
  parameter CLK_MHZ = `SPME_CLK_MHZ
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Control
  input wire start_i,
  input wire abort_i,
  input wire [2:0] ct_sel_i,
  // Status
  output reg sample_tick_o,
  output reg done_o
);

  localparam integer SAMPLE_DIV_FULL = (CLK_MHZ * 1000) / `SPME_SAMPLE_KHZ;
  localparam [15:0] SAMPLE_DIV = SAMPLE_DIV_FULL[15:0];

  reg busy_reg;
  reg [23:0] cnt_reg;
  reg [15:0] div_reg;

  // Cycles for one conversion duration select code
  function [23:0] ct_cycles;
    input [2:0] sel;
    reg [31:0] cyc;
    begin
      case (sel)
        3'h0: cyc = `SPME_CT0_US * CLK_MHZ;
        3'h1: cyc = `SPME_CT1_US * CLK_MHZ;
        3'h2: cyc = `SPME_CT2_US * CLK_MHZ;
        3'h3: cyc = `SPME_CT3_US * CLK_MHZ;
        3'h4: cyc = `SPME_CT4_US * CLK_MHZ;
        3'h5: cyc = `SPME_CT5_US * CLK_MHZ;
        3'h6: cyc = `SPME_CT6_US * CLK_MHZ;
        default: cyc = `SPME_CT7_US * CLK_MHZ;
      endcase
      // Longest duration at the default clock fits in 24 bits
      ct_cycles = cyc[23:0];
    end
  endfunction

  // Duration count and 500 kHz sample strobe while converting
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 24'h000000;
      div_reg <= 16'h0000;
      sample_tick_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      sample_tick_o <= 1'b0;
      if (abort_i) begin
        // An aborted conversion must not leave a stale done or strobe behind
        busy_reg <= 1'b0;
      end else if (start_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= ct_cycles(ct_sel_i) - 24'h000001;
        div_reg <= 16'h0000;
      end else if (busy_reg) begin
        if (cnt_reg == 24'h000000) begin
          busy_reg <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 24'h000001;
        end
        if (div_reg == SAMPLE_DIV - 16'h0001) begin
          div_reg <= 16'h0000;
          sample_tick_o <= 1'b1;
        end else begin
          div_reg <= div_reg + 16'h0001;
        end
      end
    end
  end

endmodule

/* File: sim/spme_engine_asserts.sv */
// Port checks on the shunt power measurement engine
`timescale 1ns/1ps
module spme_engine_chk #(
  parameter CLK_MHZ = 200
) (
  // Clock, reset and write port
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [7:0] wr_addr_i,
  input wire [15:0] wr_data_i,
  // Engine outputs
  input wire fe_sample_o,
  input wire [15:0] setup_o,
  input wire [15:0] cal_o,
  input wire [15:0] shunt_o,
  input wire [15:0] bus_o,
  input wire [15:0] current_o,
  input wire [15:0] power_o,
  input wire busy_o
);
  localparam int GAP = CLK_MHZ * 1000 / 500 - 1;
  reg cal_seen_reg;
  reg [15:0] gap_reg;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Calibration seen flag and cycles since the last sample strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_seen_reg <= 1'b0;
      gap_reg <= 16'hFFFF;
    end else begin
      if (wr_i && wr_addr_i == 8'h05) cal_seen_reg <= 1'b1;
      gap_reg <= fe_sample_o ? 16'h0000 : gap_reg + {15'h0000, gap_reg != 16'hFFFF};
    end
  end
  // Setup write that starts a round, then the round start
  sequence s_go;
    wr_i && wr_addr_i == 8'h00 && wr_data_i[1:0] != 2'h0;
  endsequence
  sequence s_start;
    !busy_o ##1 busy_o;
  endsequence
  chk_setup_write:
    assert property (wr_i && wr_addr_i == 8'h00 |=> setup_o == $past(wr_data_i))
    else $error("setup write lost");
  chk_cal_write:
    assert property (wr_i && wr_addr_i == 8'h05 |=> cal_o == $past(wr_data_i))
    else $error("calibration write lost");
  chk_wr_ignored:
    assert property (wr_i && wr_addr_i != 8'h00 && wr_addr_i != 8'h05
      |=> $stable(setup_o) && $stable(cal_o)) else $error("stray write taken");
  chk_bus_msb:
    assert property (bus_o[15] == 1'b0) else $error("bus top bit set");
  chk_uncal_zero:
    assert property (!cal_seen_reg |-> current_o == 16'h0000 && power_o == 16'h0000)
    else $error("result without calibration");
  chk_sample_gap:
    assert property (fe_sample_o |-> gap_reg >= GAP && busy_o) else $error("sample rate");
  chk_round_start:
    assert property (s_go |=> s_start) else $error("round start late");
  chk_results_hold:
    assert property ($changed({shunt_o, bus_o, current_o, power_o}) |-> $fell(busy_o))
    else $error("results changed outside load");
endmodule
bind spme_engine spme_engine_chk #(.CLK_MHZ(CLK_MHZ)) chk_u (.clk_i, .rst_i, .wr_i,
  .wr_addr_i, .wr_data_i, .fe_sample_o, .setup_o, .cal_o, .shunt_o, .bus_o,
  .current_o, .power_o, .busy_o);

/* File: sim/spme_fe_model.sv */
// Front end model serving shunt and bus codes to the engine
`timescale 1ns/1ps
module spme_fe_model (
  // Clock and engine strobe
  input wire clk_i,
  input wire fe_bus_sel_i,
  // Levels chosen by the bench
  input wire [15:0] code_a_i,
  input wire [15:0] code_b_i,
  input wire [15:0] bus_i,
  // Codes to the engine
  output wire [15:0] shunt_code_o,
  output wire [15:0] bus_code_o
);
  reg pick_b_reg = 1'b0;
  reg sel_d_reg = 1'b0;
  // Swap the shunt level after each bus conversion so averages mix two levels
  always @(posedge clk_i) begin
    sel_d_reg <= fe_bus_sel_i;
    if (sel_d_reg && !fe_bus_sel_i) pick_b_reg <= !pick_b_reg;
  end
  // Codes are only valid during their own conversion
  assign shunt_code_o = fe_bus_sel_i ? ~code_a_i : (pick_b_reg ? code_b_i : code_a_i);
  assign bus_code_o = fe_bus_sel_i ? bus_i : ~bus_i;
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the measurement engine
`timescale 1ns/1ps
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wr_i = 1'b0;
  reg [7:0] wr_addr_i = 8'h00;
  reg [15:0] wr_data_i = 16'h0000;
  reg [15:0] code_a = 16'h1F40;
  reg [15:0] code_b = 16'h1F40;
  reg [15:0] bus_v = 16'hA570;
  wire [15:0] sh_c, bus_c, setup_o, cal_o, shunt_o, bus_o, current_o, power_o;
  wire fe_s, fe_b, rdy, busy;
  integer fails = 0;
  integer n_tests = 0;
  integer t;
  always #2.5 clk_i = ~clk_i;
  spme_engine #(.CLK_MHZ(1)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .shunt_code_i(sh_c), .bus_code_i(bus_c),
    .fe_sample_o(fe_s), .fe_bus_sel_o(fe_b), .setup_o(setup_o), .cal_o(cal_o),
    .shunt_o(shunt_o), .bus_o(bus_o), .current_o(current_o), .power_o(power_o),
    .conv_ready_o(rdy), .busy_o(busy));
  spme_fe_model fe_u (.clk_i(clk_i), .fe_bus_sel_i(fe_b), .code_a_i(code_a),
    .code_b_i(code_b), .bus_i(bus_v), .shunt_code_o(sh_c), .bus_code_o(bus_c));
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge clk_i);
      wr_i = 1'b1;
      wr_addr_i = a;
      wr_data_i = d;
      @(negedge clk_i);
      wr_i = 1'b0;
    end
  endtask
  // Waits for ready, then checks the round length against lo cycles
  task span(input integer lo);
    begin
      t = 0;
      while (rdy !== 1'b1 && t < 20000) begin
        @(negedge clk_i);
        t = t + 1;
      end
      chk({15'h0000, t < lo || t > lo + lo / 32 + 16}, 16'h0000);
    end
  endtask
  task t_uncal;
    begin
      chk(setup_o, 16'h4127);
      chk(current_o | power_o | cal_o, 16'h0000);
      span(2200);
      chk(current_o | power_o, 16'h0000);
      chk(bus_o, 16'h2570);
      chk(shunt_o, 16'h1F40);
      wr(8'h01, 16'h0000);
      chk(setup_o, 16'h4127);
    end
  endtask
  task t_cal;
    begin
      wr(8'h05, 16'h0A00);
      wr(8'h00, 16'h0003);
      span(280);
      chk({15'h0000, busy}, 16'h0000);
      chk(current_o, 16'h2710);
      chk(power_o, 16'h12B8);
      code_a = 16'hE0C0;
      code_b = 16'hE0C0;
      wr(8'h00, 16'h0003);
      span(280);
      chk(current_o, 16'hD8F0);
      chk(power_o, 16'hED48);
    end
  endtask
  task t_avg;
    begin
      code_a = 16'h1F40;
      code_b = 16'h1F44;
      bus_v = 16'h4E20;
      wr(8'h05, 16'h0800);
      wr(8'h00, 16'h020B);
      span(1376);
      chk(shunt_o, 16'h1F42);
      chk(current_o, 16'h1F42);
      chk(power_o, 16'h1F42);
      chk(bus_o, 16'h4E20);
      bus_v = 16'h1234;
      wr(8'h00, 16'h0039);
      span(8244);
      chk(bus_o, 16'h4E20);
    end
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    t_uncal;
    t_cal;
    t_avg;
    end_sim;
  end
  // Watchdog
  initial begin
    #200000;
    fails = fails + 1;
    end_sim;
  end
endmodule
